/* File: pwm_status_pkg.sv */
// Constants for the waveform controller status, interrupt and reset-force block
package pwm_status_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_MATRIX    = 5'h00;
    localparam logic [4:0] OFS_IRQ_EN    = 5'h04;
    localparam logic [4:0] OFS_IRQ_FLAG  = 5'h08;
    localparam logic [4:0] OFS_FULL_CFG  = 5'h0c;
    localparam logic [4:0] OFS_RED_CFG   = 5'h10;
    localparam logic [4:0] OFS_CTRL      = 5'h14;
    localparam logic [4:0] OFS_ENH_FLAG  = 5'h18;
    // Flag, enable and control bit positions
    localparam int BIT_OUT_B_ACT = 7;
    localparam int BIT_OUT_A_ACT = 6;
    localparam int BIT_SYNC_ERR  = 5;
    localparam int BIT_EVENT_B   = 4;
    localparam int BIT_EVENT_A   = 3;
    localparam int BIT_RAMP_LO   = 1;
    localparam int BIT_ENH_END   = 1;
    localparam int BIT_CYCLE_END = 0;
    localparam int BIT_RUN       = 0;
    localparam int BIT_AUTORUN   = 2;
    // Fuse byte bit positions
    localparam int FUSE_FULL     = 7;
    localparam int FUSE_AUX      = 6;
    localparam int FUSE_REDUCED  = 5;
    localparam int FUSE_LEVEL    = 4;
    localparam int FUSE_INPUT    = 3;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    // Masks and reset values
    localparam logic [7:0] IRQ_EN_MASK   = 8'h3b;
    localparam logic [7:0] FLAG_W1C_MASK = 8'hf9;
    localparam logic [7:0] IRQ_SRC_MASK  = 8'h39;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // Enhanced cycle length in waveform cycles
    localparam int         ENH_CYCLES    = 15;
    localparam logic [3:0] ENH_LAST      = 4'(ENH_CYCLES - 1);
endpackage : pwm_status_pkg

/* File: pin_reset_force.sv */
// Reset-time forcing of controller output pins and input pull-ups
`timescale 1ns/1ps
module pin_reset_force import pwm_status_pkg::*; (
    // Reset and fuses
    input  wire logic       nrst,
    input  wire logic [7:0] fuse_byte,
    // Hold state from the register block
    input  wire logic       full_hold,
    input  wire logic       aux_hold,
    input  wire logic       reduced_hold,
    // Normal port levels: full a, b, aux a, aux b, reduced a, reduced b
    input  wire logic [5:0] port_out,
    output wire logic [5:0] pad_out,
    // Pull-up requests: full in a, full in b, reduced in, reduced in a, reduced in b
    input  wire logic [4:0] port_pullup,
    output wire logic [4:0] pad_pullup
);
    wire       level      = fuse_byte[FUSE_LEVEL];
    wire       full_frc   = full_hold & (fuse_byte[FUSE_FULL] == FUSE_PROGRAMMED);
    wire       aux_frc    = aux_hold & (fuse_byte[FUSE_AUX] == FUSE_PROGRAMMED);
    wire       red_frc    = reduced_hold & (fuse_byte[FUSE_REDUCED] == FUSE_PROGRAMMED);
    wire       in_frc     = ~nrst & (fuse_byte[FUSE_INPUT] == FUSE_PROGRAMMED);
    wire [5:0] force_sel  = {red_frc, red_frc, aux_frc, aux_frc, full_frc, full_frc};
    wire [4:0] pull_sel   = {1'b0, {4{in_frc}}};

    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_out
            assign pad_out[i] = force_sel[i] ? level : port_out[i];
        end
        for (i = 0; i < 5; i++) begin : g_pull
            assign pad_pullup[i] = pull_sel[i] | port_pullup[i];
        end
    endgenerate
endmodule : pin_reset_force

/* File: pwm_status_regs.sv */
// Register, flag, interrupt and reset-force logic of the waveform controller
`timescale 1ns/1ps
module pwm_status_regs import pwm_status_pkg::*; (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Waveform engine status
    input  wire logic        out_a_wave,
    input  wire logic        out_b_wave,
    input  wire logic [1:0]  ramp_num,
    input  wire logic        cycle_end,
    input  wire logic        own_update,
    input  wire logic        master_update,
    input  wire logic        master_run,
    input  wire logic        event_a,
    input  wire logic        event_b,
    // Engine controls
    output logic             out_a_level,
    output logic             out_b_level,
    output logic             run_active,
    output logic             irq,
    // Fuses and pins
    input  wire logic [7:0]  fuse_byte,
    input  wire logic [5:0]  port_out,
    output wire logic [5:0]  pad_out,
    input  wire logic [4:0]  port_pullup,
    output wire logic [4:0]  pad_pullup
);
    // Registers
    logic [7:0] output_matrix_levels;
    logic [7:0] irq_enable_mask;
    logic [7:0] irq_flag_status;
    logic [7:0] full_out_config;
    logic [7:0] reduced_out_config;
    logic [7:0] ctrl;
    logic       enh_flag;
    logic [3:0] enh_cnt;
    logic       prev_a;
    logic       prev_b;
    logic       full_hold;
    logic       aux_hold;
    logic       reduced_hold;

    // Bus decode
    wire        req       = read | write;
    wire        acc       = req & ~waitrequest;
    wire        wr_lo     = write & ~waitrequest & byteenable[0];
    wire        wr_matrix = wr_lo & (address == OFS_MATRIX);
    wire        wr_irq_en = wr_lo & (address == OFS_IRQ_EN);
    wire        wr_flag   = wr_lo & (address == OFS_IRQ_FLAG);
    wire        wr_full   = wr_lo & (address == OFS_FULL_CFG);
    wire        wr_red    = wr_lo & (address == OFS_RED_CFG);
    wire        wr_ctrl   = wr_lo & (address == OFS_CTRL);
    wire        wr_enh    = wr_lo & (address == OFS_ENH_FLAG);

    // Read mux, unmapped reads zero
    wire [7:0]  rd_byte   = (address == OFS_MATRIX)   ? output_matrix_levels :
                            (address == OFS_IRQ_EN)   ? irq_enable_mask :
                            (address == OFS_IRQ_FLAG) ? irq_flag_status :
                            (address == OFS_FULL_CFG) ? full_out_config :
                            (address == OFS_RED_CFG)  ? reduced_out_config :
                            (address == OFS_CTRL)     ? ctrl :
                            (address == OFS_ENH_FLAG) ? {7'h00, enh_flag} : 8'h00;

    // Hardware set sources
    wire        autorun   = ctrl[BIT_AUTORUN];
    wire        any_event = event_a | event_b;
    wire        enh_event = cycle_end & (enh_cnt == ENH_LAST);
    wire [7:0]  flag_set;
    assign flag_set[BIT_OUT_B_ACT] = out_b_wave ^ prev_b;
    assign flag_set[BIT_OUT_A_ACT] = out_a_wave ^ prev_a;
    assign flag_set[BIT_SYNC_ERR]  = autorun & (own_update ^ master_update);
    assign flag_set[BIT_EVENT_B]   = event_b;
    assign flag_set[BIT_EVENT_A]   = event_a;
    assign flag_set[2:1]           = 2'b00;
    assign flag_set[BIT_CYCLE_END] = cycle_end;
    wire [7:0]  flag_clr  = wr_flag ? (writedata[7:0] & FLAG_W1C_MASK) : 8'h00;
    wire [7:0]  next_flags;

    // Sticky flags, set wins over clear; ramp field bits 2:1 load ramp_num on any event
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_flag
            if (FLAG_W1C_MASK[i]) begin : g_w1c
                assign next_flags[i] = (irq_flag_status[i] & ~flag_clr[i]) | flag_set[i];
            end else if (i == BIT_RAMP_LO) begin : g_ramp_lo
                assign next_flags[i] = any_event ? ramp_num[0] : irq_flag_status[i];
            end else begin : g_ramp_hi
                assign next_flags[i] = any_event ? ramp_num[1] : irq_flag_status[i];
            end
        end
    endgenerate

    wire        next_enh  = (enh_flag & ~(wr_enh & writedata[0])) | enh_event;
    wire        enh_irq   = enh_flag & irq_enable_mask[BIT_ENH_END];
    wire        next_irq  = (|(irq_flag_status & irq_enable_mask & IRQ_SRC_MASK)) | enh_irq;
    wire        next_run  = ctrl[BIT_RUN] | (autorun & master_run);
    wire        next_a    = output_matrix_levels[{1'b0, ramp_num}];
    wire        next_b    = output_matrix_levels[{1'b1, ramp_num}];

    // Bus handshake: one wait cycle, then one accept cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= ~(req & waitrequest);
            if (read & waitrequest) begin
                readdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Software registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            output_matrix_levels <= REG_RESET;
            irq_enable_mask      <= REG_RESET;
            full_out_config      <= REG_RESET;
            reduced_out_config   <= REG_RESET;
            ctrl                 <= REG_RESET;
        end else begin
            if (wr_matrix) begin
                output_matrix_levels <= writedata[7:0];
            end
            if (wr_irq_en) begin
                irq_enable_mask <= writedata[7:0] & IRQ_EN_MASK;
            end
            if (wr_full) begin
                full_out_config <= writedata[7:0];
            end
            if (wr_red) begin
                reduced_out_config <= writedata[7:0];
            end
            if (wr_ctrl) begin
                ctrl <= writedata[7:0];
            end
        end
    end

    // Flags, enhanced cycle count, edge history
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_status <= REG_RESET;
            enh_flag        <= 1'b0;
            enh_cnt         <= 4'h0;
            prev_a          <= 1'b0;
            prev_b          <= 1'b0;
        end else begin
            irq_flag_status <= next_flags;
            enh_flag        <= next_enh;
            prev_a          <= out_a_wave;
            prev_b          <= out_b_wave;
            if (enh_event) begin
                enh_cnt <= 4'h0;
            end else if (cycle_end) begin
                enh_cnt <= enh_cnt + 4'h1;
            end
        end
    end

    // Outputs and reset holds
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq          <= 1'b0;
            run_active   <= 1'b0;
            out_a_level  <= 1'b0;
            out_b_level  <= 1'b0;
            full_hold    <= 1'b1;
            aux_hold     <= 1'b1;
            reduced_hold <= 1'b1;
        end else begin
            irq         <= next_irq;
            run_active  <= next_run;
            out_a_level <= next_a;
            out_b_level <= next_b;
            if (wr_full) begin
                full_hold <= 1'b0;
                aux_hold  <= 1'b0;
            end
            if (wr_red) begin
                reduced_hold <= 1'b0;
            end
        end
    end

    // Pin forcing
    pin_reset_force u_force (
        .nrst         (nrst),
        .fuse_byte    (fuse_byte),
        .full_hold    (full_hold),
        .aux_hold     (aux_hold),
        .reduced_hold (reduced_hold),
        .port_out     (port_out),
        .pad_out      (pad_out),
        .port_pullup  (port_pullup),
        .pad_pullup   (pad_pullup)
    );

    // Checks
    matrix_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 out_a_level == $past(output_matrix_levels[{1'b0, ramp_num}]))
        else $error("output A level does not follow matrix bit of ramp");

    sync_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
        irq_flag_status[BIT_SYNC_ERR] && irq_enable_mask[BIT_SYNC_ERR] |=> irq)
        else $error("sync error did not raise interrupt");

    event_b_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
        event_b && irq_enable_mask[BIT_EVENT_B] && !wr_irq_en |-> ##2 irq)
        else $error("event B did not raise interrupt");

    event_a_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
        event_a && irq_enable_mask[BIT_EVENT_A] && !wr_irq_en |-> ##2 irq)
        else $error("event A did not raise interrupt");

    enh_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
        cycle_end && enh_cnt == ENH_LAST |=> enh_flag && enh_cnt == 4'h0)
        else $error("enhanced cycle end not flagged after fifteen cycles");

    cycle_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
        irq_flag_status[BIT_CYCLE_END] && irq_enable_mask[BIT_CYCLE_END] |=> irq)
        else $error("cycle end did not raise interrupt");

    act_b_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(out_b_wave) |=> irq_flag_status[BIT_OUT_B_ACT])
        else $error("output B edge not flagged");

    act_a_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(out_a_wave) |=> irq_flag_status[BIT_OUT_A_ACT])
        else $error("output A edge not flagged");

    sync_err_a: assert property (@(posedge core_clk) disable iff (!nrst)
        autorun && own_update != master_update |=> irq_flag_status[BIT_SYNC_ERR])
        else $error("sync mismatch not flagged");

    event_flags_a: assert property (@(posedge core_clk) disable iff (!nrst)
        event_b |=> irq_flag_status[BIT_EVENT_B])
        else $error("event B not flagged");

    event_a_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        event_a |=> irq_flag_status[BIT_EVENT_A])
        else $error("event A not flagged");

    ramp_field_a: assert property (@(posedge core_clk) disable iff (!nrst)
        any_event |=> irq_flag_status[2:1] == $past(ramp_num))
        else $error("ramp field not captured on event");

    flag_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_flag && writedata[BIT_CYCLE_END] && !cycle_end |=> !irq_flag_status[BIT_CYCLE_END])
        else $error("cycle end flag not cleared by writing one");

    irq_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (irq_flag_status & irq_enable_mask & IRQ_SRC_MASK) == 8'h00 && !enh_irq |=> !irq)
        else $error("interrupt held with no enabled flag");

    run_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
        autorun && master_run |=> run_active)
        else $error("autorun slave did not start with master");

    hold_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_full |=> !full_hold && !aux_hold)
        else $error("full outputs still held after config write");

    act_b_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_flag && writedata[BIT_OUT_B_ACT] && !flag_set[BIT_OUT_B_ACT]
            |=> !irq_flag_status[BIT_OUT_B_ACT])
        else $error("output B activity flag not cleared by writing one");

    act_a_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_flag && writedata[BIT_OUT_A_ACT] && !flag_set[BIT_OUT_A_ACT]
            |=> !irq_flag_status[BIT_OUT_A_ACT])
        else $error("output A activity flag not cleared by writing one");

    sync_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_flag && writedata[BIT_SYNC_ERR] && !flag_set[BIT_SYNC_ERR]
            |=> !irq_flag_status[BIT_SYNC_ERR])
        else $error("sync error flag not cleared by writing one");

    event_b_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_flag && writedata[BIT_EVENT_B] && !event_b
            |=> !irq_flag_status[BIT_EVENT_B])
        else $error("event B flag not cleared by writing one");

    event_a_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_flag && writedata[BIT_EVENT_A] && !event_a
            |=> !irq_flag_status[BIT_EVENT_A])
        else $error("event A flag not cleared by writing one");

    cycle_end_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        cycle_end |=> irq_flag_status[BIT_CYCLE_END])
        else $error("cycle end not flagged");

    ramp_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !any_event |=> $stable(irq_flag_status[2:1]))
        else $error("ramp field changed without an event");

    matrix_b_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 out_b_level == $past(output_matrix_levels[{1'b1, ramp_num}]))
        else $error("output B level does not follow matrix bit of ramp");

    run_own_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrl[BIT_RUN] |=> run_active)
        else $error("run bit did not start the controller");

    run_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !ctrl[BIT_RUN] && !(autorun && master_run) |=> !run_active)
        else $error("controller running with no start source");

    red_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_red |=> !reduced_hold)
        else $error("reduced outputs still held after config write");

    full_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        full_hold && !wr_full |=> full_hold)
        else $error("full output hold dropped without config write");

    aux_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        aux_hold && !wr_full |=> aux_hold)
        else $error("auxiliary output hold dropped without config write");

    red_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        reduced_hold && !wr_red |=> reduced_hold)
        else $error("reduced output hold dropped without config write");

    enh_irq_a: assert property (@(posedge core_clk) disable iff (!nrst)
        enh_flag && irq_enable_mask[BIT_ENH_END] |=> irq)
        else $error("enhanced cycle end did not raise interrupt");

    enh_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_enh && writedata[0] && !enh_event |=> !enh_flag)
        else $error("enhanced end flag not cleared by writing one");

    enh_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
        cycle_end && !enh_event |=> enh_cnt == $past(enh_cnt) + 4'h1)
        else $error("enhanced cycle count did not advance on cycle end");

    enh_still_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !cycle_end |=> $stable(enh_cnt))
        else $error("enhanced cycle count moved without cycle end");

    en_reserved_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (irq_enable_mask & ~IRQ_EN_MASK) == 8'h00)
        else $error("reserved interrupt enable bit set");
endmodule : pwm_status_regs

/* File: engine_model.sv */
// Waveform engine and output stage model facing the status block
`timescale 1ns/1ps
module engine_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Controls from the block and the bench
    input  wire logic       run_active,
    input  wire logic       out_a_level,
    input  wire logic       out_b_level,
    input  wire logic       adv,
    // Engine status back to the block
    output logic      [1:0] ramp_num,
    output logic            cycle_end,
    output logic            out_a_wave,
    output logic            out_b_wave
);
    // Ramp advances only while running; a wrap past ramp 3 ends the cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ramp_num   <= 2'h0;
            cycle_end  <= 1'b0;
            out_a_wave <= 1'b0;
            out_b_wave <= 1'b0;
        end else begin
            out_a_wave <= out_a_level;
            out_b_wave <= out_b_level;
            cycle_end  <= adv && run_active && ramp_num == 2'h3;
            if (adv && run_active) begin
                ramp_num <= ramp_num + 2'h1;
            end
        end
    end
endmodule : engine_model

/* File: tb_top.sv */
// Self-checking bench for the status, interrupt and reset-force block
`timescale 1ns/1ps
module tb_top import pwm_status_pkg::*;;
    logic        core_clk, nrst, read, write, adv, own_update, master_update;
    logic        master_run, event_a, event_b, out_a_wave, out_b_wave, cycle_end;
    logic        out_a_level, out_b_level, run_active, irq, waitrequest;
    logic [4:0]  address, port_pullup, pad_pullup;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata;
    logic [1:0]  ramp_num, exp_ramp;
    logic [7:0]  fuse_byte, q, m;
    logic [5:0]  port_out, pad_out;
    int          error_cnt, check_count, i;

    pwm_status_regs i_dut (.core_clk, .nrst, .address, .read, .write, .byteenable,
        .writedata, .readdata, .waitrequest, .out_a_wave, .out_b_wave, .ramp_num,
        .cycle_end, .own_update, .master_update, .master_run, .event_a, .event_b,
        .out_a_level, .out_b_level, .run_active, .irq, .fuse_byte, .port_out,
        .pad_out, .port_pullup, .pad_pullup);
    engine_model i_engine (.core_clk, .nrst, .run_active, .out_a_level, .out_b_level,
        .adv, .ramp_num, .cycle_end, .out_a_wave, .out_b_wave);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [5:0] exp_pad(logic [7:0] f, logic [5:0] p, logic [2:0] h);
        logic [5:0] fm;
        fm = {{2{h[2] & !f[FUSE_REDUCED]}}, {2{h[1] & !f[FUSE_AUX]}}, {2{h[0] & !f[FUSE_FULL]}}};
        return (p & ~fm) | (fm & {6{f[FUSE_LEVEL]}});
    endfunction : exp_pad

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc

    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        read      <= !wr;
        write     <= wr;
        address   <= a;
        writedata <= {24'h0, d};
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic step();
        @(posedge core_clk);
        adv <= 1'b1;
        @(posedge core_clk);
        adv <= 1'b0;
        exp_ramp = exp_ramp + 2'h1;
    endtask : step

    task automatic pulse(input logic [3:0] k);
        @(posedge core_clk);
        {master_update, own_update, event_b, event_a} <= k;
        @(posedge core_clk);
        {master_update, own_update, event_b, event_a} <= 4'h0;
    endtask : pulse

    task automatic do_reset(input logic [7:0] f);
        @(posedge core_clk);
        fuse_byte   <= f;
        port_out    <= 6'($urandom);
        port_pullup <= 5'($urandom);
        nrst        <= 1'b0;
        cyc(3);
        chk(8'(pad_out), 8'(exp_pad(f, port_out, 3'h7)));
        chk(8'(pad_pullup), {3'h0, port_pullup[4], port_pullup[3:0] | {4{!f[FUSE_INPUT]}}});
        nrst <= 1'b1;
        exp_ramp = 2'h0;
    endtask : do_reset

    task automatic report_and_stop();
        $display("Counts: errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        {read, write, adv, own_update, master_update, master_run, event_a, event_b} = 8'h0;
        {address, writedata, port_out, port_pullup, fuse_byte} = '0;
        byteenable = 4'h1;
        nrst = 1'b0;
        error_cnt = 0;
        check_count = 0;
        exp_ramp = 2'h0;
        i = $urandom(32'hd2b04492);
        do_reset(8'h07);
        do_reset(8'hf8);
        do_reset(8'h17);
        @(posedge core_clk);
        chk(8'(pad_out), 8'(exp_pad(8'h17, port_out, 3'h7)));
        chk(8'(pad_pullup), 8'(port_pullup));
        bus(1'b1, OFS_FULL_CFG, 8'h00);
        @(posedge core_clk);
        chk(8'(pad_out), 8'(exp_pad(8'h17, port_out, 3'h4)));
        bus(1'b1, OFS_RED_CFG, 8'h00);
        @(posedge core_clk);
        chk(8'(pad_out), 8'(port_out));
        for (i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 8'h00);
            chk(q, 8'h00);
        end
        bus(1'b1, OFS_IRQ_EN, 8'hff);
        bus(1'b0, OFS_IRQ_EN, 8'h00);
        chk(q, 8'h3b);
        byteenable <= 4'h0;
        bus(1'b1, OFS_MATRIX, 8'h5a);
        byteenable <= 4'h1;
        bus(1'b0, OFS_MATRIX, 8'h00);
        chk(q, 8'h00);
        // Enhanced end after fifteen whole cycles
        bus(1'b1, OFS_IRQ_EN, 8'h02);
        bus(1'b1, OFS_CTRL, 8'h01);
        repeat (56) step();
        cyc(3);
        chk(8'(irq), 8'h00);
        repeat (4) step();
        cyc(3);
        chk(8'(irq), 8'h01);
        bus(1'b0, OFS_ENH_FLAG, 8'h00);
        chk(q, 8'h01);
        bus(1'b0, OFS_IRQ_FLAG, 8'h00);
        chk(q & 8'h01, 8'h01);
        bus(1'b1, OFS_ENH_FLAG, 8'h01);
        cyc(3);
        chk(8'(irq), 8'h00);
        bus(1'b1, OFS_IRQ_EN, 8'h01);
        cyc(3);
        chk(8'(irq), 8'h01);
        bus(1'b1, OFS_IRQ_FLAG, 8'h01);
        cyc(3);
        chk(8'(irq), 8'h00);
        // Events in every ramp, enable alternating
        for (i = 0; i < 8; i++) begin
            m = 8'($urandom);
            step();
            bus(1'b1, OFS_IRQ_EN, i[0] ? 8'h18 : 8'h00);
            bus(1'b1, OFS_IRQ_FLAG, 8'hff);
            pulse(4'(1 << m[0]));
            cyc(3);
            chk(8'(irq), 8'(i[0]));
            bus(1'b0, OFS_IRQ_FLAG, 8'h00);
            chk(q & 8'h1e, {3'h0, m[0], !m[0], exp_ramp, 1'b0});
        end
        m = 8'($urandom);
        bus(1'b1, OFS_MATRIX, m);
        for (i = 0; i < 4; i++) begin
            step();
            cyc(2);
            chk(8'({out_b_level, out_a_level}), 8'({m[4 + exp_ramp], m[exp_ramp]}));
        end
        bus(1'b1, OFS_MATRIX, 8'h00);
        cyc(3);
        bus(1'b1, OFS_IRQ_FLAG, 8'hff);
        bus(1'b0, OFS_IRQ_FLAG, 8'h00);
        chk(q & 8'hc0, 8'h00);
        bus(1'b1, OFS_MATRIX, 8'hff);
        cyc(3);
        bus(1'b0, OFS_IRQ_FLAG, 8'h00);
        chk(q & 8'hc0, 8'hc0);
        bus(1'b1, OFS_IRQ_FLAG, 8'h40);
        bus(1'b0, OFS_IRQ_FLAG, 8'h00);
        chk(q & 8'hc0, 8'h80);
        // Autorun slave and synchronisation error
        bus(1'b1, OFS_CTRL, 8'h04);
        bus(1'b1, OFS_IRQ_EN, 8'h20);
        bus(1'b1, OFS_IRQ_FLAG, 8'hff);
        master_run <= 1'b1;
        cyc(2);
        chk(8'(run_active), 8'h01);
        master_run <= 1'b0;
        cyc(2);
        chk(8'(run_active), 8'h00);
        pulse(4'hc);
        cyc(3);
        chk(8'(irq), 8'h00);
        pulse(4'h4);
        cyc(3);
        chk(8'(irq), 8'h01);
        bus(1'b1, OFS_IRQ_FLAG, 8'h20);
        cyc(3);
        chk(8'(irq), 8'h00);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
